// ---- bench/xpc_crosspoint_control_checker.sv ----
// concurrent checks on the crosspoint control ports
`timescale 1ns/100ps
`default_nettype none
module xpc_crosspoint_control_checker #(
   parameter int NumPorts = 16,
   parameter int HotplugCycles = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // restore inputs
   input wire logic restoreValid,
   input wire logic [NumPorts*xpc_pkg::PortW-1:0] restoreMap,
   // watched outputs
   input wire logic [NumPorts*xpc_pkg::PortW-1:0] routeMap,
   input wire logic [NumPorts*xpc_pkg::PortW-1:0] retainMap,
   input wire logic [NumPorts-1:0] hotplugLow,
   input wire logic [NumPorts*xpc_pkg::EdidW-1:0] emuEntry,
   input wire logic [NumPorts-1:0] emuDynamic,
   input wire logic lockLamp,
   input wire logic immediate_commit_mode,
   input wire logic edidCmdError
);
   int hpCnt_q;
   // length of the current hot-plug pulse on input 2
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hpCnt_q <= 0;
      end else begin
         hpCnt_q <= hotplugLow[2] ? hpCnt_q + 1 : 0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   hp_len_a: assert property ($fell(hotplugLow[2]) |-> hpCnt_q == HotplugCycles)
      else $error("hot-plug pulse length wrong");
   // the entry output lags the hot-plug line by one register stage
   hp_cause_a: assert property ($rose(hotplugLow[2]) && !emuDynamic[2] |=>
      $changed(emuEntry[20:14]))
      else $error("hot-plug without edid change");
   err_hold_a: assert property (edidCmdError |-> $stable(emuEntry))
      else $error("refused command changed edid");
   static_range_a: assert property (!emuDynamic[2] |-> emuEntry[20:14] inside {[1:100]})
      else $error("static entry out of range");
   emu_indep_a: assert property ($changed(emuEntry[20:14]) |->
      $stable(emuEntry[13:7]) && $stable(emuEntry[27:21]))
      else $error("neighbour edid disturbed");
   lock_hold_a: assert property ((lockLamp && !restoreValid) [*4] |=> $stable(routeMap))
      else $error("route changed while locked");
   mode_lock_a: assert property ($changed(immediate_commit_mode) |-> !lockLamp)
      else $error("mode changed while locked");
   restore_a: assert property ((restoreValid && $stable(restoreMap)) [*3] |->
      routeMap == restoreMap)
      else $error("restored map not applied");
   // restore loads the map, the retained copy follows one stage later
   retain_a: assert property (restoreValid |-> ##2 retainMap == $past(restoreMap, 2))
      else $error("retained map stale");
   cover property ($rose(hotplugLow[2]));
   cover property ($rose(immediate_commit_mode));
   cover property (edidCmdError);
   cover property (restoreValid [*3]);
endmodule : xpc_crosspoint_control_checker

bind xpc_crosspoint_control xpc_crosspoint_control_checker #(
   .NumPorts(NumPorts), .HotplugCycles(HotplugCycles)
) xpc_crosspoint_control_checker_inst (
   .clk(clk), .rst(rst), .restoreValid(restoreValid), .restoreMap(restoreMap),
   .routeMap(routeMap), .retainMap(retainMap), .hotplugLow(hotplugLow),
   .emuEntry(emuEntry), .emuDynamic(emuDynamic), .lockLamp(lockLamp),
   .immediate_commit_mode(immediate_commit_mode), .edidCmdError(edidCmdError)
);
`default_nettype wire

// ---- bench/xpc_crosspoint_control_tb.sv ----
// self-checking bench for the crosspoint control block
`timescale 1ns/100ps
`default_nettype none
module xpc_crosspoint_control_tb;
   localparam int Dst = 16;
   localparam int Commit = 32;
   localparam int Load = 33;
   localparam int Save = 34;
   localparam int Lock = 35;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [36:0] pins = '0;
   logic edidCmdValid = 1'b0;
   logic edidCmdReady;
   xpc_pkg::xpc_edid_cmd_t edidCmd = '0;
   logic ddcClk, learnStrobe;
   xpc_pkg::xpc_learn_t learnData;
   logic restoreValid = 1'b0;
   logic [63:0] restoreMap = '0;
   logic [63:0] routeMap, retainMap, expMap;
   logic [111:0] emuEntry;
   logic [15:0] hotplugLow, emuDynamic, dstLamp, srcLamp;
   logic lockLamp, immediate_commit_mode, edidCmdError;
   int failures = 0;
   int checksDone = 0;

   always #25 clk = ~clk;

   xpc_crosspoint_control #(.HotplugCycles(20), .LongPressCycles(8)) xpc_crosspoint_control_inst (
      .clk(clk), .rst(rst), .srcBtn(pins[15:0]), .dstBtn(pins[31:16]), .commitBtn(pins[32]),
      .loadBtn(pins[33]), .saveBtn(pins[34]), .lockBtn(pins[35]), .outLockBtn(pins[36]),
      .edidCmdValid(edidCmdValid), .edidCmdReady(edidCmdReady), .edidCmd(edidCmd),
      .ddcClk(ddcClk), .learnStrobe(learnStrobe), .learnData(learnData),
      .restoreValid(restoreValid), .restoreMap(restoreMap), .routeMap(routeMap),
      .retainMap(retainMap), .hotplugLow(hotplugLow), .emuEntry(emuEntry),
      .emuDynamic(emuDynamic), .srcLamp(srcLamp), .dstLamp(dstLamp), .lockLamp(lockLamp),
      .immediate_commit_mode(immediate_commit_mode), .edidCmdError(edidCmdError)
   );
   xpc_ddc_sink xpc_ddc_sink_inst (.ddcClk(ddcClk), .learnStrobe(learnStrobe),
      .learnData(learnData));

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checksDone++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   // press one panel pin; gap keeps buttons well apart for the synchronisers
   task automatic tap(input int b, input int hold);
      pins[b] = 1'b1;
      repeat (hold) @(negedge clk);
      pins[b] = 1'b0;
      repeat (8) @(negedge clk);
   endtask : tap

   task automatic protect(input int j);
      pins[36] = 1'b1;
      repeat (4) @(negedge clk);
      tap(Dst + j, 4);
      pins[36] = 1'b0;
      repeat (4) @(negedge clk);
   endtask : protect

   // one edid command; valid stays up for a back-to-back follower unless drop is set
   task automatic edid(input logic dyn, input logic [3:0] inp, input logic [6:0] ent,
         input logic [3:0] outp, input logic drop);
      int n = 0;
      edidCmd = {dyn, inp, ent, outp};
      edidCmdValid = 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (!edidCmdReady && n < 50);
      if (n >= 50) begin
         failures++;
         summarize();
      end
      @(negedge clk);
      if (drop) edidCmdValid = 1'b0;
   endtask : edid

   initial begin
      for (int i = 0; i < 16; i++) expMap[4*i +: 4] = 4'(i);
      repeat (16) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check("route", routeMap, expMap);
      for (int i = 0; i < 16; i++) check("emu", emuEntry[7*i +: 7], 64'h1);
      check("hotplug", hotplugLow, 64'h0);
      check("mode", immediate_commit_mode, 64'h0);
      $display("test reset done");
      tap(3, 4);
      check("src lamp", srcLamp, 64'h0008);
      tap(Dst + 5, 4);
      tap(Dst + 6, 4);
      check("route before take", routeMap, expMap);
      tap(Commit, 4);
      expMap[20 +: 4] = 4'h3;
      expMap[24 +: 4] = 4'h3;
      check("route", routeMap, expMap);
      $display("test deferred done");
      protect(5);
      check("dst lamp", dstLamp[5], 64'h1);
      tap(7, 4);
      tap(Dst + 5, 4);
      tap(Dst + 4, 4);
      tap(Commit, 4);
      expMap[16 +: 4] = 4'h7;
      check("route", routeMap, expMap);
      protect(5);
      check("dst lamp", dstLamp[5], 64'h0);
      $display("test protect done");
      tap(Commit, 14);
      check("mode", immediate_commit_mode, 64'h1);
      tap(9, 4);
      tap(Dst + 2, 4);
      expMap[8 +: 4] = 4'h9;
      check("route", routeMap, expMap);
      tap(Save, 4);
      tap(4, 4);
      tap(0, 4);
      tap(Dst + 2, 4);
      expMap[8 +: 4] = 4'h0;
      check("route", routeMap, expMap);
      tap(Load, 4);
      tap(4, 4);
      expMap[8 +: 4] = 4'h9;
      check("preset", routeMap, expMap);
      $display("test immediate and preset done");
      tap(Lock, 4);
      check("lock lamp", lockLamp, 64'h1);
      tap(1, 4);
      tap(Dst + 0, 4);
      tap(Commit, 14);
      check("route", routeMap, expMap);
      check("mode", immediate_commit_mode, 64'h1);
      tap(Lock, 4);
      check("lock lamp", lockLamp, 64'h0);
      $display("test lock done");
      edid(1'b0, 4'h2, 7'd60, 4'h0, 1'b1);
      repeat (6) @(negedge clk);
      check("emu", emuEntry[14 +: 7], 64'd60);
      check("hotplug", hotplugLow, 64'h0004);
      repeat (25) @(negedge clk);
      check("hotplug end", hotplugLow, 64'h0);
      edid(1'b0, 4'h2, 7'd60, 4'h0, 1'b1);
      repeat (6) @(negedge clk);
      check("hotplug same", hotplugLow, 64'h0);
      edid(1'b0, 4'h2, 7'd0, 4'h0, 1'b1);
      repeat (6) @(negedge clk);
      edid(1'b0, 4'h2, 7'd101, 4'h0, 1'b1);
      repeat (6) @(negedge clk);
      check("emu refused", emuEntry[14 +: 7], 64'd60);
      edid(1'b0, 4'h2, 7'd100, 4'h0, 1'b0);
      edid(1'b0, 4'h3, 7'd51, 4'h0, 1'b1);
      repeat (6) @(negedge clk);
      check("emu", {emuEntry[21 +: 7], emuEntry[14 +: 7]}, {51'd51, 7'd100});
      check("hotplug", hotplugLow, 64'h000c);
      repeat (25) @(negedge clk);
      $display("test static edid done");
      edid(1'b1, 4'h4, 7'd1, 4'h1, 1'b1);
      repeat (30) @(negedge clk);
      check("dynamic", emuDynamic[4], 64'h1);
      fork
         xpc_ddc_sink_inst.present(4'h3, 16'h1234);
         begin
            repeat (16) @(negedge clk);
            check("other output", hotplugLow[4], 64'h0);
         end
      join
      fork
         xpc_ddc_sink_inst.present(4'h1, 16'h5a5a);
         begin
            repeat (16) @(negedge clk);
            check("tracked output", hotplugLow[4], 64'h1);
         end
      join
      repeat (30) @(negedge clk);
      $display("test dynamic edid done");
      for (int i = 0; i < 16; i++) expMap[4*i +: 4] = 4'(15 - i);
      restoreMap = expMap;
      restoreValid = 1'b1;
      repeat (4) @(negedge clk);
      restoreValid = 1'b0;
      repeat (4) @(negedge clk);
      check("restore", routeMap, expMap);
      check("retain", retainMap, expMap);
      $display("test restore done");
      summarize();
   end
endmodule : xpc_crosspoint_control_tb
`default_nettype wire

// ---- bench/xpc_ddc_sink.sv ----
// display sink side: learned edid reports over the ddc link clock
`timescale 1ns/100ps
`default_nettype none
module xpc_ddc_sink (
   // link toward the control block
   output logic ddcClk,
   output logic learnStrobe,
   output var xpc_pkg::xpc_learn_t learnData
);
   initial begin
      ddcClk = 1'b0;
      learnStrobe = 1'b0;
      learnData = '0;
   end
   // one frame of four link periods; the link clock stands still between frames
   task automatic present(input logic [3:0] idx, input logic [15:0] sig);
      #37;
      learnStrobe = 1'b1;
      learnData = {idx, sig};
      repeat (4) begin
         #200 ddcClk = 1'b1;
         #200 ddcClk = 1'b0;
      end
      learnStrobe = 1'b0;
      // released lines show the inverse so a stale report cannot pass
      learnData = ~learnData;
   endtask : present
endmodule : xpc_ddc_sink
`default_nettype wire

// ---- design/xpc_buf2.sv ----
// two-entry valid/ready buffer
`timescale 1ns/100ps
`default_nettype none
module xpc_buf2 #(
   parameter int Width = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [Width-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [Width-1:0] outData
);
   logic [Width-1:0] mem_q [2];
   logic rdPtr_q, wrPtr_q;
   logic [1:0] count_q;
   wire logic push = inValid && inReady;
   wire logic pop = outValid && outReady;

   assign inReady = count_q != 2'h2;
   assign outValid = count_q != 2'h0;
   assign outData = mem_q[rdPtr_q];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdPtr_q <= 1'b0;
         wrPtr_q <= 1'b0;
         count_q <= 2'h0;
      end else begin
         if (push) wrPtr_q <= ~wrPtr_q;
         if (pop) rdPtr_q <= ~rdPtr_q;
         count_q <= 2'(count_q + {1'b0, push} - {1'b0, pop});
      end
   end

   always_ff @(posedge clk) begin
      if (push) mem_q[wrPtr_q] <= inData;
   end
endmodule : xpc_buf2
`default_nettype wire

// ---- design/xpc_crosspoint_control.sv ----
// crosspoint routing, edid emulation select, hot-plug and front panel control
`timescale 1ns/100ps
`default_nettype none
module xpc_crosspoint_control #(
   parameter int NumPorts = xpc_pkg::NumPorts,
   parameter int HotplugCycles = xpc_pkg::HotplugCycles,
   parameter int LongPressCycles = xpc_pkg::LongPressCycles
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // front panel buttons (pins, asynchronous)
   input wire logic [NumPorts-1:0] srcBtn,
   input wire logic [NumPorts-1:0] dstBtn,
   input wire logic commitBtn,
   input wire logic loadBtn,
   input wire logic saveBtn,
   input wire logic lockBtn,
   input wire logic outLockBtn,
   // edid command stream from the control processor
   input wire logic edidCmdValid,
   output logic edidCmdReady,
   input wire xpc_pkg::xpc_edid_cmd_t edidCmd,
   // learned edid reports from outputs, on the ddc link clock
   input wire logic ddcClk,
   input wire logic learnStrobe,
   input wire xpc_pkg::xpc_learn_t learnData,
   // retained routing restored at power-up
   input wire logic restoreValid,
   input wire logic [NumPorts*xpc_pkg::PortW-1:0] restoreMap,
   // outputs
   output logic [NumPorts*xpc_pkg::PortW-1:0] routeMap,
   output logic [NumPorts*xpc_pkg::PortW-1:0] retainMap,
   output logic [NumPorts-1:0] hotplugLow,
   output logic [NumPorts*xpc_pkg::EdidW-1:0] emuEntry,
   output logic [NumPorts-1:0] emuDynamic,
   output logic [NumPorts-1:0] srcLamp,
   output logic [NumPorts-1:0] dstLamp,
   output logic lockLamp,
   output logic immediate_commit_mode,
   output logic edidCmdError
);
   localparam int PW = xpc_pkg::PortW;
   localparam int EW = xpc_pkg::EdidW;
   localparam int LW = $bits(xpc_pkg::xpc_learn_t);
   localparam int CW = $bits(xpc_pkg::xpc_edid_cmd_t);

   // refuse sizes the port fields and counters cannot serve
   if (NumPorts < 1 || NumPorts > 16) begin : gBadPorts
      $error("NumPorts must be 1..16");
   end
   if (HotplugCycles < 1 || LongPressCycles < 1) begin : gBadCounts
      $error("counts must be positive");
   end

   // synchronisers: every pin passes two flops
   localparam int SW = 2 * NumPorts + 7;
   logic [SW-1:0] pinMeta_q, pin_q, pinPrev_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinMeta_q <= '0;
         pin_q <= '0;
         pinPrev_q <= '0;
      end else begin
         pinMeta_q <= {srcBtn, dstBtn, commitBtn, loadBtn, saveBtn, lockBtn, outLockBtn,
            ddcClk, learnStrobe};
         pin_q <= pinMeta_q;
         pinPrev_q <= pin_q;
      end
   end
   wire logic [SW-1:0] rise = pin_q & ~pinPrev_q;
   wire logic [SW-1:0] fall = ~pin_q & pinPrev_q;
   wire logic [NumPorts-1:0] srcPress = rise[SW-1 -: NumPorts];
   wire logic [NumPorts-1:0] dstPress = rise[NumPorts+6 -: NumPorts];
   wire logic commitHeld = pin_q[6];
   wire logic commitRel = fall[6];
   wire logic loadPress = rise[5];
   wire logic savePress = rise[4];
   wire logic lockPress = rise[3];
   wire logic outLockHeld = pin_q[2];
   wire logic ddcRise = rise[1];
   wire logic learnLevel = pin_q[0];

   // learned data bus is sampled on the synchronised link clock edge
   logic [LW-1:0] learnMeta_q, learnBus_q;
   logic learnHit_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         learnMeta_q <= '0;
         learnBus_q <= '0;
         learnHit_q <= 1'b0;
      end else begin
         learnMeta_q <= learnData;
         learnBus_q <= learnMeta_q;
         learnHit_q <= ddcRise && learnLevel;
      end
   end

   // learned edid signature per output, held after unplug
   logic [15:0] learned_q [NumPorts];
   logic [NumPorts-1:0] learnedValid_q;
   logic [NumPorts-1:0] learnChanged;
   xpc_pkg::xpc_learn_t lrn;
   assign lrn = learnBus_q;

   // edid command stream through the two-entry buffer
   logic cmdValid;
   logic [CW-1:0] cmdBits;
   xpc_pkg::xpc_edid_cmd_t cmd;
   assign cmd = cmdBits;
   xpc_buf2 #(.Width(CW)) xpc_buf2_inst (
      .clk(clk),
      .rst(rst),
      .inValid(edidCmdValid),
      .inReady(edidCmdReady),
      .inData(edidCmd),
      .outValid(cmdValid),
      .outReady(1'b1),
      .outData(cmdBits)
   );
   // static entry numbers are 1..100; anything else is refused
   wire logic cmdOk = cmd.dynamic ? (32'(cmd.out_sel) < NumPorts)
      : (cmd.entry != 7'h00 && cmd.entry <= xpc_pkg::LastEdid);
   wire logic cmdTake = cmdValid && cmdOk && 32'(cmd.input_sel) < NumPorts;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) edidCmdError <= 1'b0;
      else edidCmdError <= cmdValid && !cmdTake;
   end

   // panel state
   logic locked_q, immediate_q, longDone_q;
   logic [31:0] pressCnt_q;
   xpc_pkg::xpc_panel_t panel_q;
   logic [PW-1:0] pendSrc_q;
   logic pendSrcValid_q;
   logic [NumPorts-1:0] pendDst_q, protect_q;
   logic [PW-1:0] map_q [NumPorts];
   logic [PW-1:0] preset_q [xpc_pkg::NumPresets][NumPorts];
   logic [PW-1:0] srcIdx;
   logic [PW-1:0] srcSlot;

   always_comb begin
      srcIdx = '0;
      for (int i = 0; i < NumPorts; i++) begin
         if (srcPress[i]) srcIdx = PW'(i);
      end
      srcSlot = srcIdx;
   end

   wire logic panelOn = !locked_q;
   wire logic shortCommit = panelOn && commitRel && !longDone_q;
   wire logic applyNow = shortCommit && !immediate_q && pendSrcValid_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) locked_q <= 1'b0;
      else if (lockPress) locked_q <= !locked_q;
   end

   // long press toggles switching mode; release ends the press
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pressCnt_q <= '0;
         longDone_q <= 1'b0;
         immediate_q <= 1'b0;
      end else if (!commitHeld || !panelOn) begin
         pressCnt_q <= '0;
         if (!commitHeld) longDone_q <= 1'b0;
      end else if (!longDone_q) begin
         if (pressCnt_q == 32'(LongPressCycles - 1)) begin
            immediate_q <= !immediate_q;
            longDone_q <= 1'b1;
         end else begin
            pressCnt_q <= pressCnt_q + 32'h0000_0001;
         end
      end
   end

   // output protection: hold output-lock and press destination to toggle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) protect_q <= '0;
      else if (panelOn && outLockHeld) protect_q <= protect_q ^ dstPress;
   end

   // panel sequence: source/destination selection, preset load and save
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         panel_q <= xpc_pkg::PnIdle;
         pendSrc_q <= '0;
         pendSrcValid_q <= 1'b0;
         pendDst_q <= '0;
      end else if (panelOn) begin
         case (panel_q)
            xpc_pkg::PnIdle: begin
               if (loadPress) panel_q <= xpc_pkg::PnLoad;
               else if (savePress) panel_q <= xpc_pkg::PnSave;
               else if (|srcPress) begin
                  pendSrc_q <= srcIdx;
                  pendSrcValid_q <= 1'b1;
                  if (!immediate_q) panel_q <= xpc_pkg::PnShow;
               end
               if (!outLockHeld) pendDst_q <= pendDst_q ^ dstPress;
               if (applyNow) begin
                  pendDst_q <= '0;
                  pendSrcValid_q <= 1'b0;
               end
            end
            xpc_pkg::PnShow: begin
               if (|srcPress) pendSrc_q <= srcIdx;
               if (!outLockHeld) pendDst_q <= pendDst_q ^ dstPress;
               if (applyNow) begin
                  pendDst_q <= '0;
                  pendSrcValid_q <= 1'b0;
                  panel_q <= xpc_pkg::PnIdle;
               end
            end
            xpc_pkg::PnLoad, xpc_pkg::PnSave: begin
               if (|srcPress) panel_q <= xpc_pkg::PnIdle;
            end
            default: panel_q <= xpc_pkg::PnIdle;
         endcase
      end
   end

   wire logic doLoad = panelOn && panel_q == xpc_pkg::PnLoad && |srcPress;
   wire logic doSave = panelOn && panel_q == xpc_pkg::PnSave && |srcPress;

   // preset memory
   always_ff @(posedge clk) begin
      if (doSave) begin
         for (int o = 0; o < NumPorts; o++) preset_q[srcSlot][o] <= map_q[o];
      end
   end

   // per-output crosspoint, learned edid and per-input emulation
   logic [EW-1:0] entry_q [NumPorts];
   logic [PW-1:0] track_q [NumPorts];
   logic [NumPorts-1:0] dyn_q, contentChg;
   logic [31:0] hpCnt_q [NumPorts];

   genvar g;
   generate
      for (g = 0; g < NumPorts; g++) begin : gPort
         wire logic dstSel = immediate_q ? (pendDst_q[g] | dstPress[g]) && pendSrcValid_q
            : pendDst_q[g] && applyNow;
         wire logic immHit = immediate_q && panelOn && panel_q == xpc_pkg::PnIdle
            && !outLockHeld && ((dstPress[g] && pendSrcValid_q) || (|srcPress && pendDst_q[g]));
         wire logic [PW-1:0] immSrc = |srcPress ? srcIdx : pendSrc_q;

         // crosspoint: any input on any output, independent per output
         always_ff @(posedge clk or posedge rst) begin
            if (rst) map_q[g] <= PW'(g);
            else if (restoreValid) map_q[g] <= restoreMap[g*PW +: PW];
            else if (!protect_q[g]) begin
               if (doLoad) map_q[g] <= preset_q[srcSlot][g];
               else if (immHit) map_q[g] <= immSrc;
               else if (!immediate_q && dstSel) map_q[g] <= pendSrc_q;
            end
         end

         // learned edid kept until a new valid one arrives
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               learned_q[g] <= '0;
               learnedValid_q[g] <= 1'b0;
            end else if (learnHit_q && 32'(lrn.output_idx) == g) begin
               learned_q[g] <= lrn.signature;
               learnedValid_q[g] <= 1'b1;
            end
         end
         assign learnChanged[g] = learnHit_q && 32'(lrn.output_idx) == g
            && (!learnedValid_q[g] || learned_q[g] != lrn.signature);

         // emulation select per input; only the addressed input changes
         wire logic selHit = cmdTake && 32'(cmd.input_sel) == g;
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               entry_q[g] <= 7'h01;
               track_q[g] <= '0;
               dyn_q[g] <= 1'b0;
            end else if (selHit) begin
               dyn_q[g] <= cmd.dynamic;
               entry_q[g] <= cmd.entry;
               track_q[g] <= cmd.out_sel;
            end
         end
         assign contentChg[g] = selHit ? (cmd.dynamic != dyn_q[g]
            || (cmd.dynamic ? cmd.out_sel != track_q[g] : cmd.entry != entry_q[g]))
            : dyn_q[g] && learnChanged[track_q[g]];

         // hot-plug low for the full time on a content change only
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               hpCnt_q[g] <= '0;
               hotplugLow[g] <= 1'b0;
            end else if (contentChg[g]) begin
               hpCnt_q[g] <= 32'(HotplugCycles - 1);
               hotplugLow[g] <= 1'b1;
            end else if (hpCnt_q[g] != 32'h0000_0000) begin
               hpCnt_q[g] <= hpCnt_q[g] - 32'h0000_0001;
            end else begin
               hotplugLow[g] <= 1'b0;
            end
         end

         // registered outputs; route drives at once with no sink check
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               routeMap[g*PW +: PW] <= PW'(g);
               retainMap[g*PW +: PW] <= PW'(g);
               emuEntry[g*EW +: EW] <= 7'h01;
               emuDynamic[g] <= 1'b0;
               dstLamp[g] <= 1'b0;
               srcLamp[g] <= 1'b0;
            end else begin
               routeMap[g*PW +: PW] <= map_q[g];
               retainMap[g*PW +: PW] <= map_q[g];
               emuEntry[g*EW +: EW] <= entry_q[g];
               emuDynamic[g] <= dyn_q[g];
               dstLamp[g] <= pendDst_q[g] || protect_q[g];
               srcLamp[g] <= panel_q == xpc_pkg::PnShow
                  ? map_q[g] == pendSrc_q
                  : (pendSrcValid_q && 32'(pendSrc_q) == g);
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lockLamp <= 1'b0;
         immediate_commit_mode <= 1'b0;
      end else begin
         lockLamp <= locked_q;
         immediate_commit_mode <= immediate_q;
      end
   end
endmodule : xpc_crosspoint_control
`default_nettype wire

// ---- design/xpc_pkg.sv ----
// package for the crosspoint control block: constants and carried types
// How it works
// - each output picks any input on its own; one input may feed many outputs
// - hundred edid entries; one to fifty fixed, fifty-one to hundred writable
// - each output keeps its learned display edid after unplug; reset clears it
// - input edid is a stored entry (static) or an output's learned one (dynamic)
// - dynamic inputs follow a newly learned valid edid on their tracked output
// - every input has its own emulation; changing one leaves the others alone
// - edid change is accepted while a powered source stays connected
// - after an input's edid changes its hot-plug line toggles for two seconds
// - while front panel lock is on all panel operations are ignored
// - protected outputs refuse any change of selected input except a restore
// - deferred and immediate modes; long commit press toggles; short press applies in deferred mode
// - source buttons pick input, pick preset, or show fed outputs in deferred mode
// - destination buttons pick target output; their lamps show picked or protected outputs
// - load preset fetches a stored map and applies it to outputs
// - save preset writes the whole current map into the chosen slot
// - routing survives power loss and is restored at next power-up
// - selected input drives the output at once, no sink capability check
package xpc_pkg;
   localparam int NumPorts = 16;
   localparam int PortW = 4;
   localparam int EdidEntries = 100;
   localparam int EdidW = 7;
   localparam logic [6:0] FirstUserEdid = 7'h33;
   localparam logic [6:0] LastEdid = 7'h64;
   localparam int NumPresets = 16;
   localparam int ClkHz = 20000000;
   localparam int HotplugMs = 2000;
   localparam int HotplugCycles = ClkHz / 1000 * HotplugMs;
   localparam int LongPressMs = 1000;
   localparam int LongPressCycles = ClkHz / 1000 * LongPressMs;

   typedef enum logic [3:0] {
      PnIdle = 4'b0001,
      PnLoad = 4'b0010,
      PnSave = 4'b0100,
      PnShow = 4'b1000
   } xpc_panel_t;

   // one edid selection command
   typedef struct packed {
      logic dynamic;
      logic [PortW-1:0] input_sel;
      logic [EdidW-1:0] entry;
      logic [PortW-1:0] out_sel;
   } xpc_edid_cmd_t;

   // one learned edid reference arriving from an output's ddc reader
   typedef struct packed {
      logic [PortW-1:0] output_idx;
      logic [15:0] signature;
   } xpc_learn_t;
endpackage : xpc_pkg
